/* msdc_pkg.sv */
`default_nettype none
package msdc_pkg;
  localparam int NSTRM = 8;
  localparam int AW = 12;
  localparam logic [11:0] STAT_OFF = 12'h000;
  localparam logic [11:0] MASK_OFF = 12'h004;
  localparam logic [3:0] STRM_PAGE = 4'h1;
  localparam logic [4:0] CTRL_OFF = 5'h00;
  localparam logic [4:0] CNT_OFF = 5'h04;
  localparam logic [4:0] PAR_OFF = 5'h08;
  localparam logic [4:0] M0_OFF = 5'h0C;
  localparam logic [4:0] M1_OFF = 5'h10;
  localparam int EN_BIT = 0;
  localparam int DIR_LSB = 1;
  localparam int CIRC_BIT = 3;
  localparam int DBM_BIT = 4;
  localparam int SW_BIT = 5;
  localparam int BURST_BIT = 6;
  localparam int PSZ_LSB = 8;
  localparam int MSZ_LSB = 10;
  localparam int CT_BIT = 12;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;
  localparam logic [15:0] MASK_RST = 16'h0000;
  localparam logic [15:0] STAT_RST = 16'h0000;
  localparam logic [1:0] SZ_RST = 2'h0;
  localparam logic [4:0] BURST_BEATS = 5'h04;
  localparam int BUF_BYTES = 16;
  localparam logic [1:0] HT_IDLE = 2'h0;
  localparam logic [1:0] HT_NONSEQ = 2'h2;
  localparam logic [1:0] HT_SEQ = 2'h3;
  localparam logic [2:0] HB_SINGLE = 3'h0;
  localparam logic [2:0] HB_INCR = 3'h1;
  typedef enum logic [1:0] {
    DIR_P2M = 2'h0,
    DIR_M2P = 2'h1,
    DIR_M2M = 2'h2
  } msdc_dir_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_RD = 3'h2,
    ST_WR = 3'h4
  } msdc_state_t;
endpackage : msdc_pkg
`default_nettype wire

/* msdc_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
module msdc_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [msdc_pkg::AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [2:0] hburst,
  output logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hready,
  input wire logic hresp,
  input wire logic [msdc_pkg::NSTRM-1:0] stream_req,
  output logic [msdc_pkg::NSTRM-1:0] stream_ack,
  output logic irq
);
  import msdc_pkg::*;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  function automatic logic [31:0] beat_addr(input logic [31:0] b, input logic [4:0] k,
                                            input logic [1:0] sh, input logic inc);
    beat_addr = inc ? b + ({27'h0, k} << sh) : b;
  endfunction : beat_addr

  // size 3 is reserved; folded onto word so the buffer cannot overflow
  function automatic logic [1:0] sz_ok(input logic [1:0] s);
    sz_ok = (s == 2'h3) ? 2'h2 : s;
  endfunction : sz_ok

  ////////////////////////////////////////////////////////////////
  logic [NSTRM-1:0] en_reg, circ_reg, dbm_reg, sw_reg, burst_reg, ct_reg;
  logic [1:0] dir_reg [NSTRM];
  logic [1:0] psz_reg [NSTRM];
  logic [1:0] msz_reg [NSTRM];
  logic [15:0] cnt_reg [NSTRM];
  logic [15:0] cur_reg [NSTRM];
  logic [31:0] par_reg [NSTRM];
  logic [31:0] m0_reg [NSTRM];
  logic [31:0] m1_reg [NSTRM];
  logic [31:0] mptr_reg [NSTRM];
  logic [31:0] pptr_reg [NSTRM];
  logic [15:0] stat_reg, mask_reg;
  logic [31:0] prdata_reg;
  logic bad_reg;
  msdc_state_t st_reg;
  logic [2:0] sel_reg;
  logic [4:0] nrd_reg, nwr_reg, iss_reg, dn_reg;
  logic [1:0] ssh_reg, dsh_reg, lane_reg;
  logic [31:0] sa_reg, da_reg, hwdata_reg;
  logic sinc_reg, dinc_reg, bst_reg, dph_reg;
  logic [7:0] buf_mem [BUF_BYTES];
  logic [NSTRM-1:0] pend, tc_set, err_set;
  logic any;
  logic [2:0] pick;
  logic [1:0] p_ssh, p_dsh, p_big;
  logic [4:0] p_bytes, p_rb, p_wb;
  logic act, abort, done_ev, last_ev;
  logic [4:0] n_cur;
  logic [31:0] badr, wword;
  logic [2:0] sidx;
  logic [4:0] fld;
  logic hit_stat, hit_mask, hit_strm, wr_acc;
  logic [31:0] rdval;

  ////////////////////////////////////////////////////////////////
  // request and arbitration
  always_comb begin
    for (int i = 0; i < NSTRM; i++) begin
      pend[i] = en_reg[i] && (cur_reg[i] != 16'h0) &&
                (stream_req[i] || sw_reg[i] || dir_reg[i] == DIR_M2M);
    end
    any = 1'b0;
    pick = 3'h0;
    for (int i = NSTRM - 1; i >= 0; i--) begin
      if (pend[i]) begin
        any = 1'b1;
        pick = 3'(i);
      end
    end
  end

  // chunk size: reads fill the buffer, writes drain the same bytes
  always_comb begin
    p_ssh = (dir_reg[pick] == DIR_M2P) ? msz_reg[pick] : psz_reg[pick];
    p_dsh = (dir_reg[pick] == DIR_M2P) ? psz_reg[pick] : msz_reg[pick];
    p_big = (p_ssh > p_dsh) ? p_ssh : p_dsh;
    p_bytes = (burst_reg[pick] ? BURST_BEATS : 5'h01) << p_big;
    p_rb = p_bytes >> p_ssh;
    if (cur_reg[pick] < {11'h0, p_rb}) begin
      p_rb = cur_reg[pick][4:0];
    end
    p_wb = (p_rb << p_ssh) >> p_dsh;
  end

  ////////////////////////////////////////////////////////////////
  // ahb master
  assign n_cur = (st_reg == ST_RD) ? nrd_reg : nwr_reg;
  assign abort = dph_reg && hresp;
  assign act = (st_reg != ST_IDLE) && (iss_reg < n_cur) && !abort;
  assign badr = (st_reg == ST_RD) ? beat_addr(sa_reg, iss_reg, ssh_reg, sinc_reg)
                                  : beat_addr(da_reg, iss_reg, dsh_reg, dinc_reg);
  assign haddr = badr;
  // without the burst bit every beat is its own single transfer
  assign htrans = act ? ((iss_reg == 5'h0 || !bst_reg) ? HT_NONSEQ : HT_SEQ) : HT_IDLE;
  assign hwrite = (st_reg == ST_WR);
  assign hsize = {1'b0, (st_reg == ST_WR) ? dsh_reg : ssh_reg};
  assign hburst = (bst_reg && n_cur > 5'h01) ? HB_INCR : HB_SINGLE;
  assign hwdata = hwdata_reg;
  assign done_ev = (st_reg == ST_WR) && dph_reg && hready && !hresp && (dn_reg + 5'h01 == nwr_reg);
  assign last_ev = done_ev && (cur_reg[sel_reg] == {11'h0, nrd_reg});

  always_comb begin
    wword = 32'h0;
    for (int i = 0; i < 4; i++) begin
      if (i < (1 << dsh_reg)) begin
        wword[8 * 2'(badr[1:0] + 2'(i)) +: 8] = buf_mem[4'((iss_reg << dsh_reg) + 5'(i))];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= ST_IDLE;
      sel_reg <= 3'h0;
      nrd_reg <= 5'h0;
      nwr_reg <= 5'h0;
      iss_reg <= 5'h0;
      dn_reg <= 5'h0;
      dph_reg <= 1'b0;
      lane_reg <= 2'h0;
      ssh_reg <= 2'h0;
      dsh_reg <= 2'h0;
      sa_reg <= ADDR_RST;
      da_reg <= ADDR_RST;
      sinc_reg <= 1'b0;
      dinc_reg <= 1'b0;
      bst_reg <= 1'b0;
      hwdata_reg <= 32'h0;
    end else begin
      case (st_reg)
        ST_IDLE: begin
          dph_reg <= 1'b0;
          if (any) begin
            st_reg <= ST_RD;
            sel_reg <= pick;
            nrd_reg <= p_rb;
            nwr_reg <= p_wb;
            iss_reg <= 5'h0;
            dn_reg <= 5'h0;
            ssh_reg <= p_ssh;
            dsh_reg <= p_dsh;
            bst_reg <= burst_reg[pick];
            sinc_reg <= (dir_reg[pick] != DIR_P2M);
            dinc_reg <= (dir_reg[pick] != DIR_M2P);
            sa_reg <= (dir_reg[pick] == DIR_M2P) ? mptr_reg[pick] : pptr_reg[pick];
            da_reg <= (dir_reg[pick] == DIR_M2P) ? pptr_reg[pick] : mptr_reg[pick];
          end
        end
        ST_RD, ST_WR: begin
          if (abort) begin
            st_reg <= ST_IDLE;
            dph_reg <= 1'b0;
          end else if (hready) begin
            dph_reg <= act;
            if (act) begin
              iss_reg <= iss_reg + 5'h01;
              lane_reg <= badr[1:0];
              hwdata_reg <= wword;
            end
            if (dph_reg) begin
              dn_reg <= dn_reg + 5'h01;
              if (dn_reg + 5'h01 == n_cur) begin
                iss_reg <= 5'h0;
                dn_reg <= 5'h0;
                st_reg <= (st_reg == ST_RD && nwr_reg != 5'h0) ? ST_WR : ST_IDLE;
              end
            end
          end
        end
        default: st_reg <= ST_IDLE;
      endcase
    end
  end

  // shared buffer: no reset, contents only read after being filled
  always_ff @(posedge pclk) begin
    if (st_reg == ST_RD && dph_reg && hready && !hresp) begin
      for (int i = 0; i < 4; i++) begin
        if (i < (1 << ssh_reg)) begin
          buf_mem[4'((dn_reg << ssh_reg) + 5'(i))] <= hrdata[8 * 2'(lane_reg + 2'(i)) +: 8];
        end
      end
    end
  end

  always_comb begin
    stream_ack = '0;
    if (done_ev && dir_reg[sel_reg] != DIR_M2M) begin
      stream_ack[sel_reg] = 1'b1;
    end
  end

  chk_addr_hold: assert property (htrans != HT_IDLE && !hready && !abort
                                  |=> $stable(haddr) && $stable(htrans))
    else $error("address changed while bus stalled");
  chk_burst_kind: assert property (htrans == HT_SEQ |-> hburst == HB_INCR)
    else $error("sequential beat outside an incrementing burst");
  chk_err_stop: assert property (abort
                                 |=> st_reg == ST_IDLE && htrans == HT_IDLE ##1 !en_reg[$past(sel_reg, 2)])
    else $error("bus error did not stop the stream");

  ////////////////////////////////////////////////////////////////
  // stream state: events from the engine, then software writes
  assign sidx = paddr[7:5];
  assign fld = paddr[4:0];
  assign wr_acc = psel && penable && pwrite && !bad_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_reg <= '0;
      circ_reg <= '0;
      dbm_reg <= '0;
      sw_reg <= '0;
      burst_reg <= '0;
      ct_reg <= '0;
      for (int i = 0; i < NSTRM; i++) begin
        dir_reg[i] <= DIR_P2M;
        psz_reg[i] <= SZ_RST;
        msz_reg[i] <= SZ_RST;
        cnt_reg[i] <= CNT_RST;
        cur_reg[i] <= CNT_RST;
        par_reg[i] <= ADDR_RST;
        m0_reg[i] <= ADDR_RST;
        m1_reg[i] <= ADDR_RST;
        mptr_reg[i] <= ADDR_RST;
        pptr_reg[i] <= ADDR_RST;
      end
    end else begin
      if (done_ev) begin
        cur_reg[sel_reg] <= cur_reg[sel_reg] - {11'h0, nrd_reg};
        mptr_reg[sel_reg] <= beat_addr(mptr_reg[sel_reg], nrd_reg, ssh_reg, 1'b1);
        pptr_reg[sel_reg] <= beat_addr(pptr_reg[sel_reg], nrd_reg, ssh_reg, dir_reg[sel_reg] == DIR_M2M);
        if (last_ev) begin
          if (circ_reg[sel_reg] || dbm_reg[sel_reg]) begin
            cur_reg[sel_reg] <= cnt_reg[sel_reg];
            pptr_reg[sel_reg] <= par_reg[sel_reg];
            mptr_reg[sel_reg] <= m0_reg[sel_reg];
            if (dbm_reg[sel_reg]) begin
              ct_reg[sel_reg] <= ~ct_reg[sel_reg];
              mptr_reg[sel_reg] <= ct_reg[sel_reg] ? m0_reg[sel_reg] : m1_reg[sel_reg];
            end
          end else begin
            en_reg[sel_reg] <= 1'b0;
            sw_reg[sel_reg] <= 1'b0;
          end
        end
      end
      if (abort) begin
        en_reg[sel_reg] <= 1'b0;
        sw_reg[sel_reg] <= 1'b0;
      end
      if (wr_acc && hit_strm) begin
        case (fld)
          CTRL_OFF: begin
            en_reg[sidx] <= pwdata[EN_BIT];
            dir_reg[sidx] <= pwdata[DIR_LSB +: 2];
            circ_reg[sidx] <= pwdata[CIRC_BIT];
            dbm_reg[sidx] <= pwdata[DBM_BIT];
            sw_reg[sidx] <= pwdata[SW_BIT];
            burst_reg[sidx] <= pwdata[BURST_BIT];
            psz_reg[sidx] <= sz_ok(pwdata[PSZ_LSB +: 2]);
            msz_reg[sidx] <= sz_ok(pwdata[MSZ_LSB +: 2]);
            // arming loads the working copies; a live stream keeps them
            if (pwdata[EN_BIT] && !en_reg[sidx]) begin
              ct_reg[sidx] <= pwdata[CT_BIT];
              cur_reg[sidx] <= cnt_reg[sidx];
              pptr_reg[sidx] <= par_reg[sidx];
              mptr_reg[sidx] <= pwdata[CT_BIT] ? m1_reg[sidx] : m0_reg[sidx];
            end
          end
          CNT_OFF: cnt_reg[sidx] <= pwdata[15:0];
          PAR_OFF: par_reg[sidx] <= pwdata;
          M0_OFF: m0_reg[sidx] <= pwdata;
          M1_OFF: m1_reg[sidx] <= pwdata;
          default: ;
        endcase
      end
    end
  end

  chk_circ_reload: assert property (last_ev && circ_reg[sel_reg] && !dbm_reg[sel_reg] && !wr_acc
                                    |=> en_reg[$past(sel_reg)] &&
                                        cur_reg[$past(sel_reg)] == cnt_reg[$past(sel_reg)])
    else $error("circular stream did not reload");
  chk_dbm_swap: assert property (last_ev && dbm_reg[sel_reg] && !wr_acc
                                 |=> ct_reg[$past(sel_reg)] != $past(ct_reg[sel_reg]))
    else $error("double buffer target did not switch");
  chk_pri_low: assert property (st_reg == ST_IDLE && any
                                |=> st_reg == ST_RD && (pend & ((8'h01 << sel_reg) - 8'h01)) == 8'h00
                                || $past(pend) != pend)
    else $error("lower pending stream was passed over");

  ////////////////////////////////////////////////////////////////
  // status, mask and interrupt
  always_comb begin
    tc_set = '0;
    err_set = '0;
    if (last_ev) begin
      tc_set[sel_reg] = 1'b1;
    end
    if (abort) begin
      err_set[sel_reg] = 1'b1;
    end
  end

  // only bits already shown to software are cleared; set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_reg <= STAT_RST;
    end else if (psel && penable && !pwrite && hit_stat) begin
      stat_reg <= (stat_reg & ~prdata_reg[15:0]) | {err_set, tc_set};
    end else begin
      stat_reg <= stat_reg | {err_set, tc_set};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= MASK_RST;
    end else if (wr_acc && hit_mask) begin
      mask_reg <= pwdata[15:0];
    end
  end

  assign irq = |(stat_reg & mask_reg);

  chk_tc_flag: assert property (last_ev |=> stat_reg[$past(sel_reg)])
    else $error("complete flag not raised");
  chk_rc_clear: assert property (psel && penable && !pwrite && hit_stat && prdata_reg[0] && !tc_set[0]
                                 |=> !stat_reg[0])
    else $error("status bit survived its read");

  ////////////////////////////////////////////////////////////////
  // apb slave: data sampled in setup, answered in access with no wait
  assign hit_stat = (paddr == STAT_OFF);
  assign hit_mask = (paddr == MASK_OFF);
  assign hit_strm = (paddr[11:8] == STRM_PAGE) && (fld == CTRL_OFF || fld == CNT_OFF ||
                    fld == PAR_OFF || fld == M0_OFF || fld == M1_OFF);

  always_comb begin
    rdval = 32'h0;
    if (hit_stat) begin
      rdval = {16'h0, stat_reg};
    end else if (hit_mask) begin
      rdval = {16'h0, mask_reg};
    end else if (hit_strm) begin
      case (fld)
        CTRL_OFF: begin
          rdval[EN_BIT] = en_reg[sidx];
          rdval[DIR_LSB +: 2] = dir_reg[sidx];
          rdval[CIRC_BIT] = circ_reg[sidx];
          rdval[DBM_BIT] = dbm_reg[sidx];
          rdval[SW_BIT] = sw_reg[sidx];
          rdval[BURST_BIT] = burst_reg[sidx];
          rdval[PSZ_LSB +: 2] = psz_reg[sidx];
          rdval[MSZ_LSB +: 2] = msz_reg[sidx];
          rdval[CT_BIT] = ct_reg[sidx];
        end
        CNT_OFF: rdval = {16'h0, cur_reg[sidx]};
        PAR_OFF: rdval = par_reg[sidx];
        M0_OFF: rdval = m0_reg[sidx];
        M1_OFF: rdval = m1_reg[sidx];
        default: rdval = 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0;
      bad_reg <= 1'b0;
    end else if (psel && !penable) begin
      prdata_reg <= pwrite ? 32'h0 : rdval;
      bad_reg <= !(hit_stat || hit_mask || hit_strm);
    end
  end

  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = psel && penable && bad_reg;

  cov_circ: cover property (last_ev && circ_reg[sel_reg]);
  cov_dbm: cover property (last_ev && dbm_reg[sel_reg]);
  cov_burst: cover property (htrans == HT_SEQ && hready);
  cov_err: cover property (abort);

endmodule : msdc_ctrl
`default_nettype wire

/* msdc_ahb_mem.sv */
`timescale 1ns/10ps
`default_nettype none
module msdc_ahb_mem #(
  parameter logic [7:0] ERR_ADDR = 8'hF0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hready,
  output logic hresp
);
  logic [31:0] mem [0:63];
  logic [31:0] da;
  logic [31:0] noise;
  logic dact;
  logic dwr;
  logic tog;
  logic [2:0] dsz;
  logic [3:0] be;
  ////////////////////////////////////////////////////////////////
  // slow mode inserts a wait state on every other cycle
  assign hready = !slow || tog;
  assign hresp = dact && (da[7:0] == ERR_ADDR);
  // released bus flips every cycle, so stale data never looks valid
  assign hrdata = (dact && !dwr) ? mem[da[7:2]] : noise;
  assign be = (dsz == 3'h2) ? 4'hF : (dsz == 3'h1) ? (4'h3 << da[1:0]) : (4'h1 << da[1:0]);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dact <= 1'b0;
      dwr <= 1'b0;
      da <= 32'h0;
      dsz <= 3'h0;
      tog <= 1'b0;
      noise <= 32'h5A5A_A5A5;
    end else begin
      tog <= !tog;
      noise <= ~noise;
      if (hready) begin
        for (int i = 0; i < 4; i++) begin
          if (dact && dwr && !hresp && be[i]) begin
            mem[da[7:2]][8*i +: 8] <= hwdata[8*i +: 8];
          end
        end
        dact <= htrans[1];
        da <= haddr;
        dwr <= hwrite;
        dsz <= hsize;
      end
    end
  end
endmodule : msdc_ahb_mem
`default_nettype wire

/* tb_multi_stream_dma_controller.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_multi_stream_dma_controller;
  import msdc_pkg::*;
  typedef struct {
    int n;
    logic [31:0] c;
    logic [15:0] cnt;
    logic [7:0] par;
    logic [7:0] m0;
    int src;
    int dst;
    int nw;
  } msdc_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, hwrite, hready, hresp, irq, slow, e, seen_incr;
  logic [AW-1:0] paddr;
  logic [31:0] pwdata, prdata, haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize, hburst;
  logic [NSTRM-1:0] stream_req, stream_ack;
  int error_cnt, total_checks, cyc;
  msdc_row_t rows [6];
  msdc_row_t r;
  ////////////////////////////////////////////////////////////////
  msdc_ctrl uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hburst(hburst),
    .hwdata(hwdata), .hrdata(hrdata), .hready(hready), .hresp(hresp), .stream_req(stream_req),
    .stream_ack(stream_ack), .irq(irq));
  msdc_ahb_mem mem_i (.pclk(pclk), .presetn(presetn), .slow(slow), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hrdata(hrdata), .hready(hready), .hresp(hresp));
  ////////////////////////////////////////////////////////////////
  always #10 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (htrans == HT_NONSEQ && hburst == HB_INCR) begin
      seen_incr <= 1'b1;
    end
    if (cyc == 20000) begin
      error_cnt++;
      end_sim();
    end
  end
  function automatic logic [31:0] pat(input int i);
    return {8'(i), 8'hC3, 8'(3 * i), 8'h5A};
  endfunction : pat
  function automatic logic [11:0] sa(input int n, input logic [4:0] o);
    return {STRM_PAGE, n[2:0], o};
  endfunction : sa
  function automatic logic [31:0] cw(input logic [1:0] dir, input logic [1:0] psz, input logic [1:0] msz);
    cw = 32'h1;
    cw[DIR_LSB +: 2] = dir;
    cw[PSZ_LSB +: 2] = psz;
    cw[MSZ_LSB +: 2] = msz;
  endfunction : cw
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rq,
                     output logic er);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait-state count assumed; only the global timeout ends this
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rq = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic y;
    apb(1'b1, a, d, x, y);
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] x);
    logic y;
    apb(1'b0, a, 32'h0, x, y);
  endtask : rd
  task automatic prog(input int n, input logic [31:0] c, input logic [15:0] cnt, input logic [7:0] par, m0, m1);
    wr(sa(n, PAR_OFF), {24'h0, par});
    wr(sa(n, M0_OFF), {24'h0, m0});
    wr(sa(n, M1_OFF), {24'h0, m1});
    wr(sa(n, CNT_OFF), {16'h0, cnt});
    wr(sa(n, CTRL_OFF), c);
  endtask : prog
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 500) begin
      @(posedge pclk);
      n++;
    end
    check("irq", 32'(irq), 32'h1);
  endtask : wait_irq
  task automatic wait_ack(input int s);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (stream_ack[s] !== 1'b1 && n < 500);
    check("ack", 32'(stream_ack[s]), 32'h1);
    stream_req[s] <= 1'b0;
    @(posedge pclk);
  endtask : wait_ack
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim
  ////////////////////////////////////////////////////////////////
  initial begin
    {pclk, presetn, psel, penable, pwrite, slow, seen_incr} = 7'h0;
    {paddr, pwdata, stream_req, error_cnt, total_checks, cyc} = '0;
    for (int i = 0; i < 64; i++) begin
      mem_i.mem[i] = pat(i);
    end
    rows[0] = '{0, cw(DIR_M2M, 2'h2, 2'h2), 16'h0002, 8'h00, 8'h40, 0, 16, 2};
    rows[1] = '{3, cw(DIR_M2M, 2'h0, 2'h2), 16'h0004, 8'h08, 8'h50, 2, 20, 1};
    rows[2] = '{7, cw(DIR_M2M, 2'h2, 2'h2) | (32'h1 << BURST_BIT), 16'h0004, 8'h10, 8'h60, 4, 24, 4};
    rows[3] = '{5, cw(DIR_M2P, 2'h2, 2'h2) | (32'h1 << SW_BIT), 16'h0001, 8'h80, 8'h20, 8, 32, 1};
    rows[4] = '{1, cw(DIR_M2M, 2'h2, 2'h0), 16'h0001, 8'h24, 8'h70, 9, 28, 1};
    // halfword source, reserved size 3 on the word side
    rows[5] = '{0, cw(DIR_M2M, 2'h1, 2'h3), 16'h0002, 8'h30, 8'h58, 12, 22, 1};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    check("htrans", 32'(htrans), 32'(HT_IDLE));
    check("irq", 32'(irq), 32'h0);
    for (int i = 0; i < 42; i++) begin
      rd(i < 2 ? 12'(4 * i) : sa((i - 2) / 5, 5'(4 * ((i - 2) % 5))), q);
      check("reset value", q, 32'h0);
    end
    apb(1'b1, 12'h008, 32'hFFFF_FFFF, q, e);
    check("unmapped", 32'(e), 32'h1);
    apb(1'b0, 12'h102, 32'h0, q, e);
    check("misaligned", {q[30:0], e}, 32'h1);
    wr(MASK_OFF, 32'h0000_FFFF);
    // ordinary transfers, one per row
    for (int i = 0; i < 6; i++) begin
      r = rows[i];
      prog(r.n, r.c, r.cnt, r.par, r.m0, 8'h00);
      wait_irq();
      rd(STAT_OFF, q);
      check("status", q, 32'h1 << r.n);
      rd(sa(r.n, CTRL_OFF), q);
      check("enable", 32'(q[EN_BIT]), 32'h0);
      for (int k = 0; k < r.nw; k++) begin
        check("data", mem_i.mem[r.dst + k], pat(r.src + k));
      end
    end
    check("burst", 32'(seen_incr), 32'h1);
    // two requests at once under wait states, interrupt masked
    slow <= 1'b1;
    wr(MASK_OFF, 32'h0);
    prog(4, cw(DIR_P2M, 2'h2, 2'h2), 16'h0001, 8'h84, 8'h74, 8'h00);
    prog(2, cw(DIR_P2M, 2'h2, 2'h2), 16'h0001, 8'h88, 8'h78, 8'h00);
    stream_req <= 8'h14;
    for (int n = 0; n < 100 && htrans !== HT_NONSEQ; n++) begin
      @(posedge pclk);
    end
    check("first address", haddr, 32'h0000_0088);
    wait_ack(2);
    wait_ack(4);
    check("p2m data", mem_i.mem[30], pat(34));
    check("p2m data", mem_i.mem[29], pat(33));
    check("masked irq", 32'(irq), 32'h0);
    wr(MASK_OFF, 32'h4);
    @(posedge pclk);
    check("unmasked irq", 32'(irq), 32'h1);
    rd(STAT_OFF, q);
    check("status", q, 32'h14);
    @(posedge pclk);
    check("cleared irq", 32'(irq), 32'h0);
    slow <= 1'b0;
    wr(MASK_OFF, 32'h0000_FFFF);
    // bus fault on the source
    prog(6, cw(DIR_M2M, 2'h2, 2'h2), 16'h0001, 8'hF0, 8'h7C, 8'h00);
    wait_irq();
    rd(STAT_OFF, q);
    check("error status", q, 32'h4000);
    rd(sa(6, CTRL_OFF), q);
    check("enable", 32'(q[EN_BIT]), 32'h0);
    // circular then double buffer, two chunks each
    for (int m = 0; m < 2; m++) begin
      prog(6, cw(DIR_P2M, 2'h2, 2'h2) | (32'h1 << (m ? DBM_BIT : CIRC_BIT)), 16'h0001, 8'h84, 8'h90, 8'h94);
      for (int k = 0; k < 2; k++) begin
        mem_i.mem[33] = pat(40 + k);
        stream_req[6] <= 1'b1;
        wait_ack(6);
        check("buffer", mem_i.mem[(m == 1 && k == 1) ? 37 : 36], pat(40 + k));
        rd(sa(6, CTRL_OFF), q);
        check("target", 32'(q[CT_BIT]), 32'(m == 1 && k == 0));
        check("enable", 32'(q[EN_BIT]), 32'h1);
        rd(sa(6, CNT_OFF), q);
        check("reload", q, 32'h1);
      end
      wr(sa(6, CTRL_OFF), 32'h0);
      rd(STAT_OFF, q);
    end
    end_sim();
  end
endmodule : tb_multi_stream_dma_controller
`default_nettype wire
